// *** ioc_dcr_config.sv ***
// configuration and fill registers of the instruction-side memory controller
// assumes a control register bus master that holds read or write until ack
//
// Behaviour
// - the top eight fetch address bits are matched against the base compare register, one 16 MB region.
// - the base compare register loads its eight-bit tie-off at reset.
// - the control register loads its eight-bit tie-off at reset.
// - the three-bit ratio field holds 2n-1, odd codes give 1:1 to 4:1 and even codes are unsupported.
// - the address decoder answers only while the decoder enable bit is set.
// - the fill target address register is 21 bits, cpu address bits 8 to 28, and aims fill writes.
// - every write of the fill data register advances the fill target address by one.
// - a fill data write stores its 32-bit instruction word into memory at the fill target address.
// - memory address outputs carry cpu address bits 8 to 28.
// - each register sits at the eight-bit tie-off prefix plus fixed low bits 00, 01, 10, 11.
// - the memory write address comes from the fill target address register.
// - the memory write data comes from the fill data register and feeds both banks.
// - separate even-word and odd-word enables qualify each fill write.
`timescale 1ns/100ps

module ioc_dcr_config
  import ioc_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [IOC_BASE_W-1:0] i_base_compare_tieoff,
  input wire logic [IOC_CTRL_W-1:0] i_control_tieoff,
  input wire logic [IOC_PREFIX_W-1:0] i_register_address_prefix_tieoff,
  input wire logic i_dcr_read,
  input wire logic i_dcr_write,
  input wire logic [IOC_DCR_AW-1:0] i_dcr_abus,
  input wire logic [IOC_DCR_DW-1:0] i_dcr_dbus_in,
  output logic o_dcr_ack,
  output logic [IOC_DCR_DW-1:0] o_dcr_dbus_out,
  input wire logic i_fetch_valid,
  input wire logic [IOC_CPU_AW-1:0] i_fetch_addr,
  output logic o_fetch_hit,
  output logic [IOC_FILL_AW-1:0] o_memory_read_address_out,
  output logic [IOC_FILL_AW-1:0] o_memory_write_address_out,
  output logic [IOC_FILL_DW-1:0] o_memory_write_data_out,
  output logic o_even_word_write_enable,
  output logic o_odd_word_write_enable,
  output logic [IOC_RATIO_W-1:0] o_clock_ratio_select,
  output logic o_ratio_supported
);

  logic [IOC_BASE_W-1:0] instr_region_base_compare_reg;
  logic [IOC_CTRL_W-1:0] instr_memory_control_reg;
  logic [IOC_FILL_AW-1:0] fill_target_address_reg;
  logic [IOC_FILL_DW-1:0] fill_instruction_data_reg;
  logic [IOC_DCR_DW-1:0] rd_data_reg;
  logic ack_reg;
  logic ack_read_reg;
  ioc_fill_wr_t fill_wr_reg;
  logic hit_reg;
  logic [IOC_FILL_AW-1:0] rd_addr_reg;
  ioc_ctrl_t ctrl;
  logic dcr_sel;
  logic dcr_req;
  logic req_new;
  logic wr_strobe;
  logic rd_strobe;
  logic [IOC_SUB_W-1:0] sub;
  logic fill_data_wr;
  logic top_match;

  // only defined fields are decoded, reserved bits fall away
  assign ctrl.dec_en = instr_memory_control_reg[IOC_CTRL_EN_BIT];
  assign ctrl.ratio = instr_memory_control_reg[IOC_RATIO_LSB +: IOC_RATIO_W];

  assign sub = i_dcr_abus[IOC_SUB_W-1:0];
  assign dcr_sel = i_dcr_abus[IOC_DCR_AW-1:IOC_SUB_W] == i_register_address_prefix_tieoff;
  assign dcr_req = dcr_sel && (i_dcr_read || i_dcr_write);
  // one action per request, ack stays while the master holds it
  assign req_new = dcr_req && !ack_reg;
  assign wr_strobe = req_new && i_dcr_write;
  assign rd_strobe = req_new && i_dcr_read && !i_dcr_write;
  assign fill_data_wr = wr_strobe && (sub == IOC_SUB_FILL_DATA);

  // bus handshake
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      ack_reg <= 1'b0;
      ack_read_reg <= 1'b0;
    end
    else
    begin
      ack_reg <= dcr_req;
      ack_read_reg <= dcr_req && i_dcr_read && !i_dcr_write;
    end
  end

  // base compare register
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      instr_region_base_compare_reg <= i_base_compare_tieoff;
    else if (wr_strobe && sub == IOC_SUB_BASE)
      instr_region_base_compare_reg <= i_dcr_dbus_in[IOC_BASE_W-1:0];
  end

  // control register
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      instr_memory_control_reg <= i_control_tieoff;
    else if (wr_strobe && sub == IOC_SUB_CTRL)
      instr_memory_control_reg <= i_dcr_dbus_in[IOC_CTRL_W-1:0];
  end

  // fill target address, loaded by software and stepped by fill writes
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      fill_target_address_reg <= IOC_FILL_ADDR_RST;
    else if (wr_strobe && sub == IOC_SUB_FILL_ADDR)
      fill_target_address_reg <= i_dcr_dbus_in[IOC_FILL_AW-1:0];
    else if (fill_data_wr)
      fill_target_address_reg <= fill_target_address_reg + IOC_FILL_ADDR_STEP;
  end

  // fill data register
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      fill_instruction_data_reg <= IOC_FILL_DATA_RST;
    else if (fill_data_wr)
      fill_instruction_data_reg <= i_dcr_dbus_in;
  end

  // memory write port, one pulse per fill write
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      fill_wr_reg.addr <= IOC_FILL_ADDR_RST;
      fill_wr_reg.data <= IOC_FILL_DATA_RST;
      fill_wr_reg.even_en <= 1'b0;
      fill_wr_reg.odd_en <= 1'b0;
    end
    else
    begin
      if (fill_data_wr)
      begin
        fill_wr_reg.addr <= fill_target_address_reg;
        fill_wr_reg.data <= i_dcr_dbus_in;
      end
      // lowest address bit picks the word within the 64-bit line
      fill_wr_reg.even_en <= fill_data_wr && !fill_target_address_reg[0];
      fill_wr_reg.odd_en <= fill_data_wr && fill_target_address_reg[0];
    end
  end

  // register read back
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      rd_data_reg <= IOC_RD_ZERO;
    else if (rd_strobe)
    begin
      rd_data_reg <= IOC_RD_ZERO;
      unique case (sub)
        IOC_SUB_FILL_ADDR: rd_data_reg[IOC_FILL_AW-1:0] <= fill_target_address_reg;
        IOC_SUB_FILL_DATA: rd_data_reg <= fill_instruction_data_reg;
        IOC_SUB_BASE: rd_data_reg[IOC_BASE_W-1:0] <= instr_region_base_compare_reg;
        IOC_SUB_CTRL: rd_data_reg[IOC_CTRL_W-1:0] <= instr_memory_control_reg;
      endcase
    end
  end

  // fetch decoder
  assign top_match = i_fetch_addr[IOC_TOP_MSB:IOC_TOP_LSB] == instr_region_base_compare_reg;

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      hit_reg <= 1'b0;
      rd_addr_reg <= IOC_FILL_ADDR_RST;
    end
    else
    begin
      hit_reg <= i_fetch_valid && ctrl.dec_en && top_match;
      if (i_fetch_valid)
        rd_addr_reg <= i_fetch_addr[IOC_MEM_MSB:IOC_MEM_LSB];
    end
  end

  // outputs; unselected bus data passes along the chain
  assign o_dcr_ack = ack_reg;
  assign o_dcr_dbus_out = (ack_read_reg && dcr_req) ? rd_data_reg : i_dcr_dbus_in;
  assign o_fetch_hit = hit_reg;
  assign o_memory_read_address_out = rd_addr_reg;
  assign o_memory_write_address_out = fill_wr_reg.addr;
  assign o_memory_write_data_out = fill_wr_reg.data;
  assign o_even_word_write_enable = fill_wr_reg.even_en;
  assign o_odd_word_write_enable = fill_wr_reg.odd_en;
  assign o_clock_ratio_select = ctrl.ratio;
  assign o_ratio_supported = ioc_ratio_ok(ctrl.ratio);

  // checks
  property p_base_match;
    @(posedge i_clk_sys) disable iff (i_rst)
    o_fetch_hit |-> $past(i_fetch_addr[IOC_TOP_MSB:IOC_TOP_LSB]) ==
      $past(instr_region_base_compare_reg);
  endproperty
  a_base_match: assert property (p_base_match) else $error("hit without base match");

  property p_base_reset;
    @(posedge i_clk_sys)
    i_rst |=> instr_region_base_compare_reg == $past(i_base_compare_tieoff);
  endproperty
  a_base_reset: assert property (p_base_reset) else $error("base not from tie-off");

  property p_ctrl_reset;
    @(posedge i_clk_sys)
    i_rst |=> instr_memory_control_reg == $past(i_control_tieoff);
  endproperty
  a_ctrl_reset: assert property (p_ctrl_reset) else $error("control not from tie-off");

  property p_ratio_odd;
    @(posedge i_clk_sys) disable iff (i_rst)
    o_ratio_supported == o_clock_ratio_select[0];
  endproperty
  a_ratio_odd: assert property (p_ratio_odd) else $error("ratio support wrong");

  property p_dec_off;
    @(posedge i_clk_sys) disable iff (i_rst)
    !ctrl.dec_en |=> !o_fetch_hit;
  endproperty
  a_dec_off: assert property (p_dec_off) else $error("hit while decoder off");

  property p_fill_addr_wr;
    @(posedge i_clk_sys) disable iff (i_rst)
    (wr_strobe && sub == IOC_SUB_FILL_ADDR) |=>
      fill_target_address_reg == $past(i_dcr_dbus_in[IOC_FILL_AW-1:0]);
  endproperty
  a_fill_addr_wr: assert property (p_fill_addr_wr) else $error("fill address not loaded");

  property p_fill_step;
    @(posedge i_clk_sys) disable iff (i_rst)
    fill_data_wr |=> fill_target_address_reg == $past(fill_target_address_reg) + IOC_FILL_ADDR_STEP;
  endproperty
  a_fill_step: assert property (p_fill_step) else $error("fill address not stepped");

  property p_fill_store;
    @(posedge i_clk_sys) disable iff (i_rst)
    fill_data_wr |=> (o_even_word_write_enable || o_odd_word_write_enable) &&
      o_memory_write_data_out == $past(i_dcr_dbus_in) ##1
      !o_even_word_write_enable && !o_odd_word_write_enable;
  endproperty
  a_fill_store: assert property (p_fill_store) else $error("fill word not stored once");

  property p_read_addr;
    @(posedge i_clk_sys) disable iff (i_rst)
    i_fetch_valid |=> o_memory_read_address_out == $past(i_fetch_addr[IOC_MEM_MSB:IOC_MEM_LSB]);
  endproperty
  a_read_addr: assert property (p_read_addr) else $error("read address bits wrong");

  property p_dcr_ack;
    @(posedge i_clk_sys) disable iff (i_rst)
    (dcr_req && !o_dcr_ack) |=> o_dcr_ack;
  endproperty
  a_dcr_ack: assert property (p_dcr_ack) else $error("selected access not acked");

  property p_wr_addr;
    @(posedge i_clk_sys) disable iff (i_rst)
    (o_even_word_write_enable || o_odd_word_write_enable) |->
      o_memory_write_address_out + IOC_FILL_ADDR_STEP == fill_target_address_reg;
  endproperty
  a_wr_addr: assert property (p_wr_addr) else $error("write address not fill address");

  property p_wr_data;
    @(posedge i_clk_sys) disable iff (i_rst)
    (o_even_word_write_enable || o_odd_word_write_enable) |->
      o_memory_write_data_out == fill_instruction_data_reg;
  endproperty
  a_wr_data: assert property (p_wr_data) else $error("write data not fill data");

  property p_bank_pick;
    @(posedge i_clk_sys) disable iff (i_rst)
    (o_even_word_write_enable || o_odd_word_write_enable) |->
      (o_even_word_write_enable != o_odd_word_write_enable) &&
      (o_odd_word_write_enable == o_memory_write_address_out[0]);
  endproperty
  a_bank_pick: assert property (p_bank_pick) else $error("bank enable wrong");

  property p_reserved;
    @(posedge i_clk_sys) disable iff (i_rst)
    o_clock_ratio_select == instr_memory_control_reg[IOC_RATIO_LSB +: IOC_RATIO_W];
  endproperty
  a_reserved: assert property (p_reserved) else $error("ratio field misplaced");

  c_fill_two: cover property (@(posedge i_clk_sys) disable iff (i_rst)
    o_even_word_write_enable ##[1:20] o_odd_word_write_enable);
  c_hit: cover property (@(posedge i_clk_sys) disable iff (i_rst) o_fetch_hit);
  c_read_back: cover property (@(posedge i_clk_sys) disable iff (i_rst)
    ack_read_reg && dcr_req);
  c_foreign: cover property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_dcr_read || i_dcr_write) && !dcr_sel);

endmodule

// *** ioc_dcr_master.sv ***
// processor-side model of the control register bus master
// assumes the slave acks a held request and drops ack after release
`timescale 1ns/100ps

module ioc_dcr_master
  import ioc_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_dcr_ack,
  input wire logic [IOC_DCR_DW-1:0] i_dcr_dbus_out,
  output logic o_dcr_read,
  output logic o_dcr_write,
  output logic [IOC_DCR_AW-1:0] o_dcr_abus,
  output logic [IOC_DCR_DW-1:0] o_dcr_dbus_in
);
  initial
  begin
    o_dcr_read = 1'b0;
    o_dcr_write = 1'b0;
    o_dcr_abus = 10'h000;
    o_dcr_dbus_in = 32'h00000000;
  end

  // hold request until ack or for at most 8 cycles, then release; gap gives a slow master
  task automatic xfer(input logic wr, input logic [IOC_DCR_AW-1:0] a,
                      input logic [IOC_DCR_DW-1:0] d, input int gap,
                      output logic [IOC_DCR_DW-1:0] q, output logic acked);
    int n;
    n = 0;
    repeat (gap) @(posedge i_clk_sys);
    o_dcr_write <= wr;
    o_dcr_read <= ~wr;
    o_dcr_abus <= a;
    o_dcr_dbus_in <= d;
    do
    begin
      @(posedge i_clk_sys);
      n++;
    end
    while (i_dcr_ack !== 1'b1 && n < 8);
    acked = (i_dcr_ack === 1'b1);
    q = i_dcr_dbus_out;
    o_dcr_write <= 1'b0;
    o_dcr_read <= 1'b0;
    // released data lines do not keep the old word
    o_dcr_dbus_in <= ~d;
    o_dcr_abus <= ~a;
    @(posedge i_clk_sys);
  endtask
endmodule

// *** ioc_pkg.sv ***
// package for the instruction memory configuration register block
// assumes one controller clock and a device control register bus master
package ioc_pkg;

  // register bus geometry
  localparam int IOC_DCR_AW = 10;
  localparam int IOC_DCR_DW = 32;
  localparam int IOC_PREFIX_W = 8;
  localparam int IOC_SUB_W = 2;

  // fixed low address bits of each register
  localparam logic [1:0] IOC_SUB_FILL_ADDR = 2'h0;
  localparam logic [1:0] IOC_SUB_FILL_DATA = 2'h1;
  localparam logic [1:0] IOC_SUB_BASE = 2'h2;
  localparam logic [1:0] IOC_SUB_CTRL = 2'h3;

  // register widths
  localparam int IOC_BASE_W = 8;
  localparam int IOC_CTRL_W = 8;
  localparam int IOC_FILL_AW = 21;
  localparam int IOC_FILL_DW = 32;

  // control byte fields, little-endian numbering of the big-endian byte
  localparam int IOC_CTRL_EN_BIT = 7;
  localparam int IOC_RATIO_LSB = 0;
  localparam int IOC_RATIO_W = 3;

  // cpu address fields, big-endian bit 0 is [31]
  localparam int IOC_CPU_AW = 32;
  localparam int IOC_TOP_MSB = 31;
  localparam int IOC_TOP_LSB = 24;
  localparam int IOC_MEM_MSB = 23;
  localparam int IOC_MEM_LSB = 3;

  // reset values and step
  localparam logic [IOC_FILL_AW-1:0] IOC_FILL_ADDR_RST = 21'h000000;
  localparam logic [IOC_FILL_DW-1:0] IOC_FILL_DATA_RST = 32'h00000000;
  localparam logic [IOC_FILL_AW-1:0] IOC_FILL_ADDR_STEP = 21'h000001;
  localparam logic [IOC_DCR_DW-1:0] IOC_RD_ZERO = 32'h00000000;

  typedef struct packed {
    logic [IOC_FILL_AW-1:0] addr;
    logic [IOC_FILL_DW-1:0] data;
    logic even_en;
    logic odd_en;
  } ioc_fill_wr_t;

  typedef struct packed {
    logic dec_en;
    logic [IOC_RATIO_W-1:0] ratio;
  } ioc_ctrl_t;

  // only odd codes 2n-1 are valid ratios
  function automatic logic ioc_ratio_ok(input logic [IOC_RATIO_W-1:0] code);
    ioc_ratio_ok = code[0];
  endfunction

endpackage

// *** test_instr_ocm_dcr_config.sv ***
// self-checking bench of the configuration and fill register block
// assumes the master model drives the register bus
`timescale 1ns/100ps

module test_instr_ocm_dcr_config;
  import ioc_pkg::*;
  localparam logic [7:0] PFX = 8'h0b;
  localparam logic [7:0] BASE0 = 8'h5a;
  localparam logic [7:0] CTL0 = 8'h83;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rd;
  logic wr_req;
  logic [9:0] abus;
  logic [31:0] dbin;
  logic ack;
  logic [31:0] dbout;
  logic fv = 1'b0;
  logic [31:0] fa = 32'h00000000;
  logic hit;
  logic [20:0] rda;
  logic [20:0] wra;
  logic [31:0] wrd;
  logic ev;
  logic od;
  logic [2:0] rsel;
  logic rok;
  logic [31:0] q;
  logic ok;
  logic [20:0] ea;
  int err_count = 0;
  int checks_done = 0;
  int cyc = 0;
  ioc_fill_wr_t fills[$];

  always #50 clk = ~clk;

  ioc_dcr_config dut_u (.i_clk_sys(clk), .i_rst(rst), .i_base_compare_tieoff(BASE0),
    .i_control_tieoff(CTL0), .i_register_address_prefix_tieoff(PFX), .i_dcr_read(rd),
    .i_dcr_write(wr_req), .i_dcr_abus(abus), .i_dcr_dbus_in(dbin), .o_dcr_ack(ack),
    .o_dcr_dbus_out(dbout), .i_fetch_valid(fv), .i_fetch_addr(fa), .o_fetch_hit(hit),
    .o_memory_read_address_out(rda), .o_memory_write_address_out(wra),
    .o_memory_write_data_out(wrd), .o_even_word_write_enable(ev),
    .o_odd_word_write_enable(od), .o_clock_ratio_select(rsel), .o_ratio_supported(rok));

  ioc_dcr_master mst_u (.i_clk_sys(clk), .i_dcr_ack(ack), .i_dcr_dbus_out(dbout),
    .o_dcr_read(rd), .o_dcr_write(wr_req), .o_dcr_abus(abus), .o_dcr_dbus_in(dbin));

  always @(posedge clk)
  begin
    if (ev === 1'b1 || od === 1'b1)
      fills.push_back(ioc_fill_wr_t'{wra, wrd, ev, od});
    cyc++;
    if (cyc == 5000)
    begin
      err_count++;
      test_done();
    end
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [1:0] s, input logic [31:0] d);
    mst_u.xfer(1'b1, {PFX, s}, d, 0, q, ok);
    check("write ack", 32'h1, {31'h0, ok});
  endtask

  task automatic rd_chk(input string what, input logic [1:0] s, input logic [31:0] e, input int g);
    mst_u.xfer(1'b0, {PFX, s}, 32'h0, g, q, ok);
    check(what, e, q);
  endtask

  task automatic fetch(input logic [31:0] a, input logic e);
    fv <= 1'b1;
    fa <= a;
    @(posedge clk);
    fv <= 1'b0;
    @(posedge clk);
    check("fetch hit", {31'h0, e}, {31'h0, hit});
    check("read address", {11'h0, a[23:3]}, {11'h0, rda});
  endtask

  task automatic test_end(input string name);
    $display("test %s done", name);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_chk("base reset", IOC_SUB_BASE, {24'h0, BASE0}, 0);
    rd_chk("control reset", IOC_SUB_CTRL, {24'h0, CTL0}, 2);
    rd_chk("fill address reset", IOC_SUB_FILL_ADDR, 32'h0, 0);
    check("ratio reset", {29'h0, CTL0[2:0]}, {29'h0, rsel});
    test_end("reset");
    wr(IOC_SUB_BASE, 32'h000000c3);
    rd_chk("base", IOC_SUB_BASE, 32'h000000c3, 0);
    wr(IOC_SUB_FILL_ADDR, 32'h001ffffe);
    rd_chk("fill address", IOC_SUB_FILL_ADDR, 32'h001ffffe, 1);
    test_end("registers");
    for (int i = 0; i < 3; i++)
      wr(IOC_SUB_FILL_DATA, 32'hdead0000 + i);
    check("fill count", 32'h3, fills.size());
    for (int i = 0; i < 3 && i < fills.size(); i++)
    begin
      ea = 21'h1ffffe + i[20:0];
      check("fill write address", {11'h0, ea}, {11'h0, fills[i].addr});
      check("fill write data", 32'hdead0000 + i, fills[i].data);
      check("even enable", {31'h0, ~ea[0]}, {31'h0, fills[i].even_en});
      check("odd enable", {31'h0, ea[0]}, {31'h0, fills[i].odd_en});
    end
    rd_chk("fill address step", IOC_SUB_FILL_ADDR, 32'h00000001, 0);
    rd_chk("fill data", IOC_SUB_FILL_DATA, 32'hdead0002, 0);
    test_end("fill");
    for (int c = 0; c < 8; c++)
    begin
      // reserved bits written as zero
      wr(IOC_SUB_CTRL, {24'h0, 1'b1, 4'h0, c[2:0]});
      check("ratio select", c, {29'h0, rsel});
      check("ratio supported", {31'h0, c[0]}, {31'h0, rok});
    end
    test_end("ratio");
    wr(IOC_SUB_CTRL, 32'h00000081);
    fetch(32'hc3000128, 1'b1);
    fetch(32'hc3fffff8, 1'b1);
    fetch(32'hc4000128, 1'b0);
    wr(IOC_SUB_CTRL, 32'h00000001);
    fetch(32'hc3000128, 1'b0);
    test_end("fetch");
    mst_u.xfer(1'b1, {~PFX, IOC_SUB_BASE}, 32'h00000011, 0, q, ok);
    check("foreign ack", 32'h0, {31'h0, ok});
    check("foreign pass", 32'h00000011, q);
    rd_chk("base kept", IOC_SUB_BASE, 32'h000000c3, 0);
    test_end("prefix");
    test_done();
  end
endmodule
